// ==== rtl/aob_defines.svh ====
// Constants of the converter output path: geometry, timing, register map.
// Included by the package and the design modules; definitions only.
`ifndef AOB_DEFINES_SVH
`define AOB_DEFINES_SVH

// Buffer geometry and pipeline fill count
`define AOB_WORD_W 18
`define AOB_DEPTH 16
`define AOB_PTR_W 4
`define AOB_CNT_W 5
`define AOB_CNT_FULL 5'h10
`define AOB_CNT_HALF 5'h08
`define AOB_CNT_ONE 5'h01
`define AOB_PIPE_FILL 3'h4

// Level flag codes {upper, lower}
`define AOB_FLAGS_EMPTY 2'h1
`define AOB_FLAGS_LOW 2'h0
`define AOB_FLAGS_HALF 2'h2
`define AOB_FLAGS_FULL 2'h3

// Timing: conversion time in ns, clock in MHz, cycles rounded up
`define AOB_CLK_MHZ 125
`define AOB_CONV_TIME_NS 200
`define AOB_CONV_CYC ((`AOB_CONV_TIME_NS * `AOB_CLK_MHZ + 999) / 1000)

// Register byte offsets
`define AOB_REG_CTRL 5'h00
`define AOB_REG_STATUS 5'h04
`define AOB_REG_IRQ_STAT 5'h08
`define AOB_REG_IRQ_CLR 5'h0C
`define AOB_REG_IRQ_EN 5'h10

// Control fields and reset value
`define AOB_CTRL_RUN 0
`define AOB_CTRL_FLUSH 1
`define AOB_CTRL_RESET 1'h1

// Interrupt event bits
`define AOB_IRQ_W 4
`define AOB_IRQ_DONE 0
`define AOB_IRQ_HALF 1
`define AOB_IRQ_FULL 2
`define AOB_IRQ_LOST 3

`endif

// ==== rtl/aob_fifo.sv ====
// Sixteen-word store of eighteen-bit conversion words.
// The caller never pushes when full nor pops when empty.
`timescale 1ns/1ps
`include "aob_defines.svh"

module aob_fifo
    import aob_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Control
    input wire logic push,
    input wire aob_word_t pushWord,
    input wire logic pop,
    input wire logic clear,
    // State
    output aob_word_t headWord,
    output aob_count_t count
);
    aob_word_t mem [`AOB_DEPTH];
    logic [`AOB_PTR_W-1:0] wrPtr_q, rdPtr_q;
    aob_count_t count_q;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_q] <= pushWord;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst || clear) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (pop) begin
                rdPtr_q <= rdPtr_q + 1'b1;
            end
            count_q <= count_q + aob_count_t'(push) - aob_count_t'(pop);
        end
    end

    assign headWord = mem[rdPtr_q];
    assign count = count_q;
endmodule : aob_fifo

// ==== rtl/aob_output_path.sv ====
// Digital output path of a 16-bit sampling converter: conversion timing,
// pipeline, output coding, sixteen-word buffer with level flags, and an
// Avalon-MM register slave with interrupt.
// Assumes all pins are synchronous to clk; start pulses one cycle apart or more.
//
// Functional notes
// - Select rise inserts buffer, fall bypasses it
// - Read rise presents next word; host waits
// - Last word read: empty on read fall
// - Eight to seven: below-half on read rise
// - Sixteen to fifteen: half code on rise
// - End-of-conversion fall writes word, leaves empty
// - Seven to eight words: half code
// - Sixteenth word: full code on fall
// - Select high complementary, all bits inverted; low passes bits uninverted
// - Zero between 8000/7FFF, plus full zeros
// - Three stages; valid after four starts
// - Sixteen words of eighteen bits
// - Flags: empty 01, low 00, half 10, full 11
// - Direct mode ignores buffer, passes data through
// - Direct mode with read low clears buffer
//
// Decided for this implementation: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "aob_defines.svh"

module aob_output_path
    import aob_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Converter side
    input wire logic startConv,
    input wire logic [15:0] sampleCode,
    input wire logic sampleOverflow,
    // Host control pins
    input wire logic bufferSelect,
    input wire logic readStrobe,
    input wire logic codingSelect,
    input wire logic outEnableN,
    // Host data pins
    output logic [15:0] dataOut,
    output logic signInvOut,
    output logic overflowOut,
    output logic dataOe,
    output logic eocOut,
    output logic buffer_level_flag_upper,
    output logic buffer_level_flag_lower,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Interrupt
    output logic irq
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [1:0] flagCode(input aob_count_t cnt);
        if (cnt == '0) begin
            flagCode = `AOB_FLAGS_EMPTY;
        end else if (cnt == `AOB_CNT_FULL) begin
            flagCode = `AOB_FLAGS_FULL;
        end else if (cnt >= `AOB_CNT_HALF) begin
            flagCode = `AOB_FLAGS_HALF;
        end else begin
            flagCode = `AOB_FLAGS_LOW;
        end
    endfunction : flagCode

    function automatic aob_word_t applyCoding(input aob_word_t w, input logic sel);
        applyCoding = sel ? ~w : w;
    endfunction : applyCoding

    localparam logic [7:0] CONV_CYC = 8'(`AOB_CONV_CYC);

    // ------------------------------------------------------------
    // Pin edges
    // ------------------------------------------------------------
    logic startPrev_q, selPrev_q, readPrev_q;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            startPrev_q <= 1'b0;
            selPrev_q <= 1'b0;
            readPrev_q <= 1'b1;
        end else begin
            startPrev_q <= startConv;
            selPrev_q <= bufferSelect;
            readPrev_q <= readStrobe;
        end
    end

    logic runEnable_q;
    logic startRise, selRise, selFall, readRise, readFall;
    assign startRise = startConv && !startPrev_q && runEnable_q;
    assign selRise = bufferSelect && !selPrev_q;
    assign selFall = !bufferSelect && selPrev_q;
    assign readRise = readStrobe && !readPrev_q;
    assign readFall = !readStrobe && readPrev_q;

    // ------------------------------------------------------------
    // Conversion timing
    // ------------------------------------------------------------
    aob_conv_state_t convState_q;
    logic [7:0] convCnt_q;
    logic eocFall;
    assign eocFall = (convState_q == AOB_CONV) && (convCnt_q == 8'h1) && !startRise;

    // A start during a conversion restarts it; that result is unreliable
    always_ff @(posedge clk) begin
        if (!nrst) begin
            convState_q <= AOB_IDLE;
            convCnt_q <= 8'h0;
        end else begin
            case (convState_q)
                AOB_IDLE: begin
                    if (startRise) begin
                        convState_q <= AOB_CONV;
                        convCnt_q <= CONV_CYC;
                    end
                end
                AOB_CONV: begin
                    if (startRise) begin
                        convCnt_q <= CONV_CYC;
                    end else if (convCnt_q == 8'h1) begin
                        convState_q <= AOB_IDLE;
                        convCnt_q <= 8'h0;
                    end else begin
                        convCnt_q <= convCnt_q - 8'h1;
                    end
                end
                default: begin
                    convState_q <= AOB_IDLE;
                    convCnt_q <= 8'h0;
                end
            endcase
        end
    end
    assign eocOut = (convState_q == AOB_CONV);

    // ------------------------------------------------------------
    // Pipeline
    // ------------------------------------------------------------
    aob_word_t convWord;
    logic pipeValid;
    aob_pipeline u_pipe (
        .clk(clk),
        .nrst(nrst),
        .step(startRise),
        .sampleWord({sampleOverflow, ~sampleCode[15], sampleCode}),
        .resultWord(convWord),
        .resultValid(pipeValid)
    );

    // ------------------------------------------------------------
    // Mode and buffer
    // ------------------------------------------------------------
    logic bufMode_q;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            bufMode_q <= 1'b0;
        end else if (selRise) begin
            bufMode_q <= 1'b1;
        end else if (selFall) begin
            bufMode_q <= 1'b0;
        end
    end

    aob_word_t headWord;
    aob_count_t count;
    logic flushReq_q;
    logic push, pop, clearBuf, lostWord;
    // Reads and writes only count while the buffer is in the path
    assign push = bufMode_q && eocFall && (count != `AOB_CNT_FULL);
    assign lostWord = bufMode_q && eocFall && (count == `AOB_CNT_FULL);
    assign pop = bufMode_q && !push
               && ((readRise && count > `AOB_CNT_ONE)
               || (readFall && count == `AOB_CNT_ONE));
    assign clearBuf = (!bufMode_q && !readStrobe) || flushReq_q;

    aob_fifo u_fifo (
        .clk(clk),
        .nrst(nrst),
        .push(push),
        .pushWord(convWord),
        .pop(pop),
        .clear(clearBuf),
        .headWord(headWord),
        .count(count)
    );

    // Level flags follow the occupancy one cycle later, two cycles after the causing edge
    logic [1:0] flags_q;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            flags_q <= `AOB_FLAGS_EMPTY;
        end else begin
            flags_q <= flagCode(count);
        end
    end
    assign buffer_level_flag_upper = flags_q[1];
    assign buffer_level_flag_lower = flags_q[0];

    // ------------------------------------------------------------
    // Output register
    // ------------------------------------------------------------
    logic loadHead_q;
    aob_word_t outWord_q, coded_q;
    logic oe_q;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            loadHead_q <= 1'b0;
        end else begin
            // Head is shown after an advance or a write into empty
            loadHead_q <= (pop && count > `AOB_CNT_ONE) || (push && count == '0);
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            outWord_q <= '0;
        end else if (!bufMode_q && eocFall) begin
            outWord_q <= convWord;
        end else if (loadHead_q) begin
            outWord_q <= headWord;
        end
    end

    // Coding applies to every output bit, so it can change between words
    always_ff @(posedge clk) begin
        if (!nrst) begin
            coded_q <= '0;
            oe_q <= 1'b0;
        end else begin
            coded_q <= applyCoding(outWord_q, codingSelect);
            oe_q <= !outEnableN;
        end
    end
    assign dataOut = coded_q[15:0];
    assign signInvOut = coded_q[16];
    assign overflowOut = coded_q[17];
    assign dataOe = oe_q;

    // ------------------------------------------------------------
    // Interrupt events
    // ------------------------------------------------------------
    logic [`AOB_IRQ_W-1:0] irqStat_q, irqEn_q, irqEvent, irqClr;
    always_comb begin
        irqEvent = '0;
        irqEvent[`AOB_IRQ_DONE] = eocFall;
        irqEvent[`AOB_IRQ_HALF] = push && count == `AOB_CNT_HALF - `AOB_CNT_ONE;
        irqEvent[`AOB_IRQ_FULL] = push && count == `AOB_CNT_FULL - `AOB_CNT_ONE;
        irqEvent[`AOB_IRQ_LOST] = lostWord;
    end

    logic wrAccess;
    assign wrAccess = avs_write && avs_byteenable[0];
    assign irqClr = (wrAccess && avs_address == `AOB_REG_IRQ_CLR) ?
                    avs_writedata[`AOB_IRQ_W-1:0] : '0;

    // A new event outranks a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            irqStat_q <= '0;
        end else begin
            irqStat_q <= (irqStat_q & ~irqClr) | irqEvent;
        end
    end
    assign irq = |(irqStat_q & irqEn_q);

    // ------------------------------------------------------------
    // Register slave
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            runEnable_q <= `AOB_CTRL_RESET;
            flushReq_q <= 1'b0;
            irqEn_q <= '0;
        end else begin
            flushReq_q <= wrAccess && avs_address == `AOB_REG_CTRL && avs_writedata[`AOB_CTRL_FLUSH];
            if (wrAccess && avs_address == `AOB_REG_CTRL) begin
                runEnable_q <= avs_writedata[`AOB_CTRL_RUN];
            end
            if (wrAccess && avs_address == `AOB_REG_IRQ_EN) begin
                irqEn_q <= avs_writedata[`AOB_IRQ_W-1:0];
            end
        end
    end

    // Reads take one wait cycle so the data comes from a flop
    logic readReady_q;
    logic [31:0] readData_q, readMux;
    always_comb begin
        readMux = 32'h0;
        case (avs_address)
            `AOB_REG_CTRL: readMux[`AOB_CTRL_RUN] = runEnable_q;
            `AOB_REG_STATUS: readMux[10:0] = {bufMode_q, eocOut, pipeValid, flags_q, 1'b0, count};
            `AOB_REG_IRQ_STAT: readMux[`AOB_IRQ_W-1:0] = irqStat_q;
            `AOB_REG_IRQ_EN: readMux[`AOB_IRQ_W-1:0] = irqEn_q;
            default: readMux = 32'h0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            readReady_q <= 1'b0;
            readData_q <= 32'h0;
        end else begin
            readReady_q <= avs_read && !readReady_q;
            if (avs_read && !readReady_q) begin
                readData_q <= readMux;
            end
        end
    end
    assign avs_waitrequest = avs_read && !readReady_q;
    assign avs_readdata = readData_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_select_rise;
        @(posedge clk) disable iff (!nrst)
        selRise |=> bufMode_q;
    endproperty
    a_select_rise: assert property (p_select_rise) else $error("buffer not inserted on select rise");

    property p_select_fall;
        @(posedge clk) disable iff (!nrst)
        selFall |=> !bufMode_q;
    endproperty
    a_select_fall: assert property (p_select_fall) else $error("buffer not bypassed on select fall");

    property p_flag_code;
        @(posedge clk) disable iff (!nrst)
        1'b1 |=> flags_q == flagCode($past(count));
    endproperty
    a_flag_code: assert property (p_flag_code) else $error("level flags disagree with occupancy");

    property p_read_from_full;
        @(posedge clk) disable iff (!nrst)
        (bufMode_q && readRise && !eocFall && count == `AOB_CNT_FULL && !clearBuf)
            |=> count == `AOB_CNT_FULL - `AOB_CNT_ONE ##1 flags_q == `AOB_FLAGS_HALF;
    endproperty
    a_read_from_full: assert property (p_read_from_full) else $error("full to fifteen not flagged");

    property p_read_eight;
        @(posedge clk) disable iff (!nrst)
        (bufMode_q && readRise && !eocFall && count == `AOB_CNT_HALF && !clearBuf)
            |=> ##1 flags_q == `AOB_FLAGS_LOW;
    endproperty
    a_read_eight: assert property (p_read_eight) else $error("eight to seven not flagged");

    property p_read_last;
        @(posedge clk) disable iff (!nrst)
        (bufMode_q && readFall && !eocFall && count == `AOB_CNT_ONE && !clearBuf)
            |=> ##1 flags_q == `AOB_FLAGS_EMPTY;
    endproperty
    a_read_last: assert property (p_read_last) else $error("last read did not empty buffer");

    property p_first_write;
        @(posedge clk) disable iff (!nrst)
        (bufMode_q && eocFall && count == '0 && !clearBuf)
            |=> ##2 outWord_q == $past(convWord, 3) && flags_q == `AOB_FLAGS_LOW;
    endproperty
    a_first_write: assert property (p_first_write) else $error("first word not shown");

    property p_direct_pass;
        @(posedge clk) disable iff (!nrst)
        (!bufMode_q && eocFall) |=> outWord_q == $past(convWord);
    endproperty
    a_direct_pass: assert property (p_direct_pass) else $error("direct word not passed");

    property p_direct_clear;
        @(posedge clk) disable iff (!nrst)
        (!bufMode_q && !readStrobe) |=> count == '0 ##1 flags_q == `AOB_FLAGS_EMPTY;
    endproperty
    a_direct_clear: assert property (p_direct_clear) else $error("direct mode did not clear buffer");

    property p_coding;
        @(posedge clk) disable iff (!nrst)
        nrst |=> coded_q == ($past(codingSelect) ? ~$past(outWord_q) : $past(outWord_q));
    endproperty
    a_coding: assert property (p_coding) else $error("output coding wrong");

    c_fill_full: cover property (@(posedge clk) disable iff (!nrst) push && count == `AOB_CNT_FULL - `AOB_CNT_ONE);
    c_drain_last: cover property (@(posedge clk) disable iff (!nrst) pop && count == `AOB_CNT_ONE);
    c_lost_word: cover property (@(posedge clk) disable iff (!nrst) lostWord);
    c_irq_raise: cover property (@(posedge clk) disable iff (!nrst) $rose(irq));
endmodule : aob_output_path

// ==== rtl/aob_pipeline.sv ====
// Three-stage conversion pipeline paced by start pulses.
// Assumes one start pulse per cycle at most, synchronous to clk.
`timescale 1ns/1ps
`include "aob_defines.svh"

module aob_pipeline
    import aob_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Sample side
    input wire logic step,
    input wire aob_word_t sampleWord,
    // Result side
    output aob_word_t resultWord,
    output logic resultValid
);
    aob_word_t stage0_q, stage1_q, stage2_q, result_q;
    logic [2:0] fill_q;

    // Four steps carry a sample through three stages to the result
    always_ff @(posedge clk) begin
        if (!nrst) begin
            stage0_q <= '0;
            stage1_q <= '0;
            stage2_q <= '0;
            result_q <= '0;
        end else if (step) begin
            stage0_q <= sampleWord;
            stage1_q <= stage0_q;
            stage2_q <= stage1_q;
            result_q <= stage2_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            fill_q <= 3'h0;
        end else if (step && fill_q != `AOB_PIPE_FILL) begin
            fill_q <= fill_q + 3'h1;
        end
    end

    assign resultWord = result_q;
    assign resultValid = (fill_q == `AOB_PIPE_FILL);

    property p_fill_four;
        @(posedge clk) disable iff (!nrst)
        (step && fill_q == 3'h3) |=> resultValid;
    endproperty
    a_fill_four: assert property (p_fill_four) else $error("result not valid after fourth step");
endmodule : aob_pipeline

// ==== rtl/aob_pkg.sv ====
// Types shared by the converter output path modules.
// Needs aob_defines.svh on the include path.
`include "aob_defines.svh"

package aob_pkg;
    typedef logic [`AOB_WORD_W-1:0] aob_word_t;
    typedef logic [`AOB_CNT_W-1:0] aob_count_t;
    typedef enum logic [0:0] {
        AOB_IDLE = 1'b0,
        AOB_CONV = 1'b1
    } aob_conv_state_t;
endpackage : aob_pkg

// ==== testbench/aob_host_model.sv ====
// Host-side model: samples each converted word and rebuilds two's complement.
// Assumes the output path drives its data pins and eocOut synchronously to clk.
`timescale 1ns/1ps

module aob_host_model
    import aob_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Device pins
    input wire logic eocOut,
    input wire logic [15:0] dataOut,
    input wire logic signInvOut,
    // Host view
    output logic [15:0] twosWord
);
    logic eocPrev_q;
    logic [2:0] settle_q;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            eocPrev_q <= 1'b0;
            settle_q <= 3'h0;
        end else begin
            eocPrev_q <= eocOut;
            // Wait out the load and coding stages before sampling
            if (eocPrev_q && !eocOut) begin
                settle_q <= 3'h5;
            end else if (settle_q != 3'h0) begin
                settle_q <= settle_q - 3'h1;
            end
        end
    end

    // Sign taken from the inverted output, not from the data msb
    always_ff @(posedge clk) begin
        if (!nrst) begin
            twosWord <= 16'h0000;
        end else if (settle_q == 3'h1) begin
            twosWord <= {signInvOut, dataOut[14:0]};
        end
    end
endmodule : aob_host_model

// ==== testbench/testbench.sv ====
// Self-checking bench of the converter output path and its register slave.
// Assumes aob_defines.svh on the include path and the host model beside it.
`timescale 1ns/1ps
`include "aob_defines.svh"

module testbench
    import aob_pkg::*;
;
    logic clk, nrst, startConv, sampleOverflow, bufferSelect, readStrobe, codingSelect, outEnableN;
    logic [15:0] sampleCode, dataOut, twosWord;
    logic signInvOut, overflowOut, dataOe, eocOut, irq;
    logic buffer_level_flag_upper, buffer_level_flag_lower;
    logic [4:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic [16:0] hist [0:39];
    logic [15:0] samples [0:8] = '{16'h7FFF, 16'h8000, 16'hFFFF, 16'h0000, 16'h1234, 16'hFFFF, 16'h0F0F,
                                   16'hC3C3, 16'h5A5A};
    int nStarts, numErrors, nTests, headIdx;
    wire logic [17:0] outWord = {overflowOut, signInvOut, dataOut};
    wire logic [1:0] levelFlags = {buffer_level_flag_upper, buffer_level_flag_lower};

    aob_output_path u_aob_output_path (.clk(clk), .nrst(nrst), .startConv(startConv), .sampleCode(sampleCode),
        .sampleOverflow(sampleOverflow), .bufferSelect(bufferSelect), .readStrobe(readStrobe),
        .codingSelect(codingSelect), .outEnableN(outEnableN), .dataOut(dataOut), .signInvOut(signInvOut),
        .overflowOut(overflowOut), .dataOe(dataOe), .eocOut(eocOut),
        .buffer_level_flag_upper(buffer_level_flag_upper), .buffer_level_flag_lower(buffer_level_flag_lower),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .irq(irq));
    aob_host_model u_aob_host_model (.clk(clk), .nrst(nrst), .eocOut(eocOut), .dataOut(dataOut),
        .signInvOut(signInvOut), .twosWord(twosWord));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            numErrors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic completeRun;
        $display("Comparisons %0d, mismatches %0d", nTests, numErrors);
        if (numErrors == 0 && nTests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : completeRun

    function automatic logic [17:0] coded(input logic [16:0] w, input logic cs);
        logic [17:0] raw;
        raw = {w[16], ~w[15], w[15:0]};
        return cs ? ~raw : raw;
    endfunction : coded

    // Request held until waitrequest is sampled low
    task automatic avAccess(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : avAccess

    task automatic regWrite(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        avAccess(1'b1, a, d, q);
    endtask : regWrite

    task automatic regCheck(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] q;
        avAccess(1'b0, a, 32'h0, q);
        check(q, exp);
    endtask : regCheck

    task automatic convert(input logic [15:0] code);
        int n;
        @(posedge clk);
        sampleCode <= code;
        sampleOverflow <= code[0];
        startConv <= 1'b1;
        hist[nStarts] = {code[0], code};
        nStarts++;
        @(posedge clk);
        startConv <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (eocOut !== 1'b1 && n < 5);
        while (eocOut !== 1'b0 && n < 60) begin
            @(posedge clk);
            n++;
        end
        check(n, `AOB_CONV_CYC + 1);
        repeat (8) @(posedge clk);
    endtask : convert

    task automatic setRead(input logic v);
        @(posedge clk);
        readStrobe <= v;
        repeat (5) @(posedge clk);
    endtask : setRead

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic testReset;
        check(levelFlags, `AOB_FLAGS_EMPTY);
        check(dataOe, 1'b0);
        regCheck(`AOB_REG_CTRL, 32'h1);
        regCheck(`AOB_REG_STATUS, 32'h40);
        regCheck(5'h14, 32'h0);
        @(posedge clk);
        outEnableN <= 1'b0;
        repeat (2) @(posedge clk);
        check(dataOe, 1'b1);
    endtask : testReset

    task automatic testCoding;
        logic cs;
        for (int k = 0; k < 9; k++) begin
            cs = (k < 6);
            @(posedge clk);
            codingSelect <= cs;
            convert(samples[k]);
            if (k >= 3) begin
                check(outWord, coded(hist[k - 3], cs));
                check(twosWord, hist[k - 3][15:0] ^ {16{cs}} ^ 16'h8000);
            end
        end
    endtask : testCoding

    task automatic testFill;
        @(posedge clk);
        codingSelect <= 1'b1;
        regWrite(`AOB_REG_IRQ_CLR, 32'hF);
        regWrite(`AOB_REG_IRQ_EN, 32'h6);
        @(posedge clk);
        bufferSelect <= 1'b1;
        headIdx = nStarts - 3;
        for (int i = 1; i <= 16; i++) begin
            convert(16'h0100 * i[15:0] + 16'h0033 + i[15:0]);
            check(levelFlags, i == 16 ? `AOB_FLAGS_FULL : i >= 8 ? `AOB_FLAGS_HALF : `AOB_FLAGS_LOW);
            check(outWord, coded(hist[headIdx], 1'b1));
            check(irq, i >= 8);
        end
        regCheck(`AOB_REG_STATUS, 32'h5D0);
        regCheck(`AOB_REG_IRQ_STAT, 32'h7);
        convert(16'hABCD);
        check(levelFlags, `AOB_FLAGS_FULL);
        regCheck(`AOB_REG_IRQ_STAT, 32'hF);
        regWrite(`AOB_REG_IRQ_EN, 32'h0);
        @(posedge clk);
        check(irq, 1'b0);
        regWrite(`AOB_REG_IRQ_CLR, 32'hF);
        regCheck(`AOB_REG_IRQ_STAT, 32'h0);
    endtask : testFill

    task automatic testDrain;
        for (int i = 1; i <= 15; i++) begin
            setRead(1'b0);
            setRead(1'b1);
            check(levelFlags, (16 - i >= 8) ? `AOB_FLAGS_HALF : `AOB_FLAGS_LOW);
            check(outWord, coded(hist[headIdx + i], 1'b1));
        end
        setRead(1'b0);
        check(levelFlags, `AOB_FLAGS_EMPTY);
        setRead(1'b1);
        check(outWord, coded(hist[headIdx + 15], 1'b1));
    endtask : testDrain

    task automatic testDirect;
        convert(16'h4444);
        convert(16'h5555);
        check(levelFlags, `AOB_FLAGS_LOW);
        check(outWord, coded(hist[nStarts - 5], 1'b1));
        @(posedge clk);
        bufferSelect <= 1'b0;
        convert(16'h6666);
        check(levelFlags, `AOB_FLAGS_LOW);
        check(outWord, coded(hist[nStarts - 4], 1'b1));
        setRead(1'b0);
        check(levelFlags, `AOB_FLAGS_EMPTY);
        setRead(1'b1);
    endtask : testDirect

    initial begin
        nrst = 1'b0;
        startConv = 1'b0;
        sampleCode = 16'h0000;
        sampleOverflow = 1'b0;
        bufferSelect = 1'b0;
        readStrobe = 1'b1;
        codingSelect = 1'b1;
        outEnableN = 1'b1;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        nStarts = 0;
        numErrors = 0;
        nTests = 0;
        headIdx = 0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        testReset();
        testCoding();
        testFill();
        testDrain();
        testDirect();
        completeRun();
    end

    // Full run needs about thirteen hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        numErrors++;
        completeRun();
    end
endmodule : testbench
